// [dv/uart_modem_status_inputs_bench.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module uart_modem_status_inputs_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata;
    logic [2:0] s_axi_awprot = 3'h0; // Tied, ignored by the slave
    logic [2:0] s_axi_arprot = 3'h0; // Tied, ignored by the slave
    logic [3:0] s_axi_wstrb = 4'hf; // Tied, whole words only
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, port_irq;
    umsi_pkg::umsi_pins_s want [2] = '{4'hf, 4'hf}; // Wanted pin levels
    umsi_pkg::umsi_pins_s pin1, pin2; // Pins as the modem drives them
    logic [3:0] rose [2] = '{4'h0, 4'h0}; // Expected change bits
    logic [31:0] seed, d;
    int miscompares = 0;
    int total_checks = 0;
    int i, p, n;
    always #5 aclk = ~aclk;
    umsi_modem u_modem (.aclk(aclk), .want_p1(want[0]), .want_p2(want[1]), .pins_p1(pin1),
        .pins_p2(pin2));
    umsi_top dut (.*, .clear_to_send_n_port1(pin1.cts_n), .set_ready_n_port1(pin1.dsr_n),
        .carrier_detect_n_port1(pin1.dcd_n), .ring_indicator_n_port1(pin1.ri_n),
        .clear_to_send_n_port2(pin2.cts_n), .set_ready_n_port2(pin2.dsr_n),
        .carrier_detect_n_port2(pin2.dcd_n), .ring_indicator_n_port2(pin2.ri_n));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Levels are the inverted pins, changes the rises since the last read
    function automatic logic [31:0] exp_status(input int q);
        return {24'h0, ~want[q], rose[q]};
    endfunction : exp_status
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Bus write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic haw, hw, hb;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 50; k++)
        begin
            @(negedge aclk);
            haw = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge aclk);
            if (haw) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) break;
        end
        s_axi_bready <= 1'b0;
        chk("bvalid", 32'h1, {31'h0, hb});
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr
    // Bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        logic har, hr;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 50; k++)
        begin
            @(negedge aclk);
            har = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid === 1'b1;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (har) s_axi_arvalid <= 1'b0;
            if (hr) break;
        end
        s_axi_rready <= 1'b0;
        chk("rvalid", 32'h1, {31'h0, hr});
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd
    task automatic rd_status(input int q);
        logic [31:0] v;
        rd(q ? 8'(umsi_pkg::ADDR_STATUS_P2) : 8'(umsi_pkg::ADDR_STATUS_P1), v, 2'h0);
        chk("status", exp_status(q), v);
        rose[q] = 4'h0;
    endtask : rd_status
    // New pin levels, then time for the filter to settle
    task automatic set_pin(input int q, input logic [3:0] v);
        rose[q] = rose[q] | (v & ~want[q]);
        @(posedge aclk);
        want[q] <= v;
        repeat (8) @(posedge aclk);
    endtask : set_pin
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // Status words take writes silently and keep their value
        wr(8'(umsi_pkg::ADDR_STATUS_P1), 32'hff, umsi_pkg::RESP_OKAY);
        // Every word reads zero after reset
        for (i = 0; i < 6; i++)
        begin
            rd(8'(4 * i), d, 2'h0);
            chk("reset word", 32'h0, d);
        end
        rd(8'h18, d, umsi_pkg::RESP_SLVERR);
        chk("unmapped", 32'h0, d);
        wr(8'h1c, 32'h1, umsi_pkg::RESP_SLVERR);
        $display("test reset and map done");
        // Each pin alone: fall, rise, read twice, other port untouched
        for (p = 0; p < 2; p++)
            for (i = 0; i < 4; i++)
            begin
                set_pin(p, 4'hf ^ (4'h1 << i));
                rd_status(p);
                set_pin(p, 4'hf);
                rd_status(p);
                rd_status(p);
                rd_status(1 - p);
            end
        $display("test single pins done");
        // Random levels on both ports with reads in between
        seed = 32'hd5e2;
        for (n = 0; n < 40; n++)
        begin
            seed = lfsr(seed);
            set_pin(int'(seed[4]), seed[3:0]);
            if (seed[5]) rd_status(int'(seed[6]));
        end
        rd_status(0);
        rd_status(1);
        $display("test random pins done");
        // Interrupt on any change, masking and clearing
        wr(8'(umsi_pkg::ADDR_ENABLE_P1), 32'h8, 2'h0);
        wr(8'(umsi_pkg::ADDR_IRQ_MASK), 32'h3, 2'h0);
        set_pin(0, want[0] ^ 4'h1);
        chk("port_irq", 32'h1, {30'h0, port_irq});
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'(umsi_pkg::ADDR_IRQ_STAT), 32'h1, 2'h0);
        chk("irq clear", 32'h0, {31'h0, irq});
        wr(8'(umsi_pkg::ADDR_IRQ_MASK), 32'h0, 2'h0);
        set_pin(0, want[0] ^ 4'h8);
        chk("masked irq", 32'h0, {31'h0, irq});
        rd(8'(umsi_pkg::ADDR_IRQ_STAT), d, 2'h0);
        chk("sticky", 32'h1, d);
        wr(8'(umsi_pkg::ADDR_IRQ_STAT), 32'h1, 2'h0);
        wr(8'(umsi_pkg::ADDR_ENABLE_P1), 32'h0, 2'h0);
        wr(8'(umsi_pkg::ADDR_ENABLE_P2), 32'h8, 2'h0);
        wr(8'(umsi_pkg::ADDR_IRQ_MASK), 32'h3, 2'h0);
        set_pin(0, want[0] ^ 4'h2);
        set_pin(1, want[1] ^ 4'h4);
        chk("port2 irq", 32'h2, {30'h0, port_irq});
        $display("test interrupts done");
        summarize();
    end
    // Watchdog well past the expected run length
    initial
    begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        summarize();
    end
endmodule : uart_modem_status_inputs_bench

// [dv/umsi_modem.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// Modem model driving the handshake pins of both ports
// ------------------------------------------------------------
module umsi_modem (
    input wire logic aclk,
    input wire umsi_pkg::umsi_pins_s want_p1,
    input wire umsi_pkg::umsi_pins_s want_p2,
    output umsi_pkg::umsi_pins_s pins_p1,
    output umsi_pkg::umsi_pins_s pins_p2
);
    // Pins move just after an edge, unrelated to any bus traffic
    always_ff @(posedge aclk)
    begin
        pins_p1 <= want_p1;
        pins_p2 <= want_p2;
    end
endmodule : umsi_modem

// [dv/umsi_top_props.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module umsi_top_props #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear_to_send_n_port1,
    input wire logic set_ready_n_port1,
    input wire logic carrier_detect_n_port1,
    input wire logic ring_indicator_n_port1,
    input wire logic clear_to_send_n_port2,
    input wire logic set_ready_n_port2,
    input wire logic carrier_detect_n_port2,
    input wire logic ring_indicator_n_port2,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] pins_ff; // Pins one cycle ago
    logic [3:0] quiet_ff; // Cycles since a pin moved, saturating
    logic [3:0] wgap_ff; // Cycles since a write data beat
    logic [ADDR_W-1:0] raddr_ff; // Address of the read under way
    wire logic [7:0] pins = {carrier_detect_n_port2, ring_indicator_n_port2, set_ready_n_port2,
        clear_to_send_n_port2, carrier_detect_n_port1, ring_indicator_n_port1,
        set_ready_n_port1, clear_to_send_n_port1};
    // Quiet time of the pins
    always_ff @(posedge aclk)
    begin
        pins_ff <= pins;
        if (!aresetn || pins != pins_ff)
            quiet_ff <= 4'h0;
        else if (quiet_ff != 4'hf)
            quiet_ff <= quiet_ff + 4'h1;
    end
    // Time since the last write beat
    always_ff @(posedge aclk)
    begin
        if (!aresetn || (s_axi_wvalid && s_axi_wready))
            wgap_ff <= 4'h0;
        else if (wgap_ff != 4'hf)
            wgap_ff <= wgap_ff + 4'h1;
    end
    // Read address capture
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            raddr_ff <= s_axi_araddr;
    end
    property p_lvl1;
        $rose(s_axi_rvalid) && raddr_ff == ADDR_W'(umsi_pkg::ADDR_STATUS_P1) && quiet_ff >= 4'h7
            |-> s_axi_rdata[7:4] == ~pins[3:0];
    endproperty
    a_lvl1: assert property (p_lvl1) else $error("port 1 level bits wrong");
    property p_lvl2;
        $rose(s_axi_rvalid) && raddr_ff == ADDR_W'(umsi_pkg::ADDR_STATUS_P2) && quiet_ff >= 4'h7
            |-> s_axi_rdata[7:4] == ~pins[7:4];
    endproperty
    a_lvl2: assert property (p_lvl2) else $error("port 2 level bits wrong");
    property p_irq_src;
        $rose(irq) |-> quiet_ff <= 4'h8 || wgap_ff <= 4'h4;
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("interrupt without cause");
    property p_unmapped;
        $rose(s_axi_rvalid) && raddr_ff[4:2] > 3'h5
            |-> s_axi_rresp == umsi_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_width;
        $rose(s_axi_rvalid) |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_width: assert property (p_width) else $error("upper read bits set");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_b_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
    c_irq: cover property ($rose(irq));
    c_err: cover property ($rose(s_axi_rvalid) && s_axi_rresp == umsi_pkg::RESP_SLVERR);
    c_lvl: cover property ($rose(s_axi_rvalid) && quiet_ff >= 4'h7 && s_axi_rdata[7:4] != 4'h0);
endmodule : umsi_top_props
bind umsi_top umsi_top_props #(.ADDR_W(ADDR_W)) u_props (.*);

// [logic/umsi_pkg.sv]
package umsi_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_STATUS_P1 = 5'h00;  // Modem status, port 1
    localparam logic [4:0] ADDR_ENABLE_P1 = 5'h04;  // Interrupt enable, port 1
    localparam logic [4:0] ADDR_STATUS_P2 = 5'h08;  // Modem status, port 2
    localparam logic [4:0] ADDR_ENABLE_P2 = 5'h0c;  // Interrupt enable, port 2
    localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;   // Sticky event bits, write one to clear
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;   // Event mask
    // ------------------------------------------------------------
    // Modem status field positions
    // ------------------------------------------------------------
    localparam int MS_DELTA_CTS = 0;  // Clear-to-send rose
    localparam int MS_DELTA_DSR = 1;  // Set-ready rose
    localparam int MS_DELTA_RI = 2;   // Ring indicator rose
    localparam int MS_DELTA_DCD = 3;  // Carrier detect rose
    localparam int MS_LVL_CTS = 4;    // Clear-to-send, inverted
    localparam int MS_LVL_DSR = 5;    // Set-ready, inverted
    localparam int MS_LVL_RI = 6;     // Ring indicator, inverted
    localparam int MS_LVL_DCD = 7;    // Carrier detect, inverted
    // Modem-status interrupt enable bit
    localparam int IE_MODEM_BIT = 3;
    // Width of the stored enable field
    localparam int IE_WIDTH = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] RST_PIN_LEVEL = 4'hf;   // Inputs idle high
    localparam logic [3:0] RST_DELTA = 4'h0;
    localparam logic [3:0] RST_ENABLE = 4'h0;
    localparam logic [1:0] RST_IRQ_BITS = 2'h0;
    // ------------------------------------------------------------
    // Bus answers and timing
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SYNC_STAGES = 3;  // Flops on each pin input
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Four handshake pins of one port, active low, in field order
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } umsi_pins_s;
    // One write request as it is held by the slave
    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } umsi_wreq_s;
endpackage : umsi_pkg

// [logic/umsi_top.sv]
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module umsi_top #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    // Handshake pins, port 1
    input wire logic clear_to_send_n_port1,
    input wire logic set_ready_n_port1,
    input wire logic carrier_detect_n_port1,
    input wire logic ring_indicator_n_port1,
    // Handshake pins, port 2
    input wire logic clear_to_send_n_port2,
    input wire logic set_ready_n_port2,
    input wire logic carrier_detect_n_port2,
    input wire logic ring_indicator_n_port2,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Per-port serial interrupt, and gated summary interrupt
    output logic [1:0] port_irq,
    output logic irq
);
    localparam int NPORT = 2;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Upper address bits above the word field must exist for the read decode
    if (ADDR_W < 6)
    begin : g_bad_addr
        $error("umsi_top: ADDR_W must be at least 6");
    end

    // ------------------------------------------------------------
    // Pin gathering
    // ------------------------------------------------------------
    umsi_pkg::umsi_pins_s pins [NPORT];  // Raw pins per port
    assign pins[0] = '{dcd_n: carrier_detect_n_port1, ri_n: ring_indicator_n_port1,
                       dsr_n: set_ready_n_port1, cts_n: clear_to_send_n_port1};
    assign pins[1] = '{dcd_n: carrier_detect_n_port2, ri_n: ring_indicator_n_port2,
                       dsr_n: set_ready_n_port2, cts_n: clear_to_send_n_port2};

    // ------------------------------------------------------------
    // Bus-side declarations
    // ------------------------------------------------------------
    logic aw_held_ff;                    // Write address captured
    logic w_held_ff;                     // Write data captured
    logic [4:0] awaddr_ff;               // Captured write address
    logic [31:0] wdata_ff;               // Captured write data
    logic [3:0] wstrb_ff;                // Captured byte enables
    umsi_pkg::umsi_wreq_s wreq;          // Joined write request
    logic wr_go;                         // Write performed this cycle
    logic rd_go;                         // Read taken this cycle
    logic [4:0] rd_addr;                 // Read word address
    logic [31:0] rd_word;                // Read mux result
    logic rd_hit;                        // Read address mapped
    logic wr_hit;                        // Write address mapped
    localparam int IE_W = umsi_pkg::IE_WIDTH;
    logic [IE_W-1:0] ier_ff [NPORT];     // Interrupt enable per port
    logic [3:0] delta_ff [NPORT];        // Change bits per port
    logic [3:0] level_ff [NPORT];        // Filtered pin levels
    logic [NPORT-1:0] change;            // Any pin changed, per port
    logic [NPORT-1:0] ist_ff;            // Sticky event status
    logic [NPORT-1:0] imask_ff;          // Event mask

    assign wreq = '{addr: awaddr_ff, data: wdata_ff, strb: wstrb_ff};
    assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign rd_addr = {s_axi_araddr[4:2], 2'h0};

    // ------------------------------------------------------------
    // Per-port input path
    // ------------------------------------------------------------
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        logic [3:0] s1_ff;       // First synchroniser stage
        logic [3:0] s2_ff;       // Second stage
        logic [3:0] s3_ff;       // Third stage
        logic [3:0] agree;       // Stages two and three match
        logic [3:0] rise;        // Pin went low to high
        logic [3:0] toggle;      // Pin changed either way
        logic status_read;       // This port's status read now
        logic [4:0] my_status;   // Address of this port's status

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                s1_ff <= umsi_pkg::RST_PIN_LEVEL;
                s2_ff <= umsi_pkg::RST_PIN_LEVEL;
                s3_ff <= umsi_pkg::RST_PIN_LEVEL;
            end
            else
            begin
                s1_ff <= pins[p];
                s2_ff <= s1_ff;
                s3_ff <= s2_ff;
            end
        end

        // Change counts once stages two and three agree
        assign agree = ~(s2_ff ^ s3_ff);
        assign toggle = agree & (s3_ff ^ level_ff[p]);
        assign rise = agree & s3_ff & ~level_ff[p];
        assign change[p] = |toggle;

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                level_ff[p] <= umsi_pkg::RST_PIN_LEVEL;
            else
                level_ff[p] <= (level_ff[p] & ~agree) | (s3_ff & agree);
        end

        assign my_status = (p == 0) ? umsi_pkg::ADDR_STATUS_P1 : umsi_pkg::ADDR_STATUS_P2;
        assign status_read = rd_go && (rd_addr == my_status);

        // status read clears them, a new rise wins
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                delta_ff[p] <= umsi_pkg::RST_DELTA;
            else if (status_read)
                delta_ff[p] <= rise;
            else
                delta_ff[p] <= delta_ff[p] | rise;
        end

        // Enable register write, low byte only
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                ier_ff[p] <= umsi_pkg::RST_ENABLE;
            else if (wr_go && wreq.strb[0] && wreq.addr ==
                     ((p == 0) ? umsi_pkg::ADDR_ENABLE_P1 : umsi_pkg::ADDR_ENABLE_P2))
                ier_ff[p] <= wreq.data[IE_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------
    // Separate status word per port
    function automatic logic [7:0] status_word(input logic [3:0] lvl,
                                               input logic [3:0] dlt);
        logic [7:0] w;
        w = 8'h00;
        w[umsi_pkg::MS_LVL_CTS] = ~lvl[0];
        w[umsi_pkg::MS_LVL_DSR] = ~lvl[1];
        w[umsi_pkg::MS_LVL_RI] = ~lvl[2];
        w[umsi_pkg::MS_LVL_DCD] = ~lvl[3];
        w[umsi_pkg::MS_DELTA_CTS] = dlt[0];
        w[umsi_pkg::MS_DELTA_DSR] = dlt[1];
        w[umsi_pkg::MS_DELTA_RI] = dlt[2];
        w[umsi_pkg::MS_DELTA_DCD] = dlt[3];
        return w;
    endfunction : status_word

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Enabled pin change sets sticky bit; set beats clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ist_ff <= umsi_pkg::RST_IRQ_BITS;
        else
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                if (change[p] && ier_ff[p][umsi_pkg::IE_MODEM_BIT])
                    ist_ff[p] <= 1'b1;
                else if (wr_go && wreq.strb[0] && wreq.addr == umsi_pkg::ADDR_IRQ_STAT
                         && wreq.data[p])
                    ist_ff[p] <= 1'b0;
            end
        end
    end

    // Mask register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            imask_ff <= umsi_pkg::RST_IRQ_BITS;
        else if (wr_go && wreq.strb[0] && wreq.addr == umsi_pkg::ADDR_IRQ_MASK)
            imask_ff <= wreq.data[NPORT-1:0];
    end

    // Clear-to-send feeds status and the change interrupt, never a transmit gate
    assign port_irq = ist_ff & imask_ff;
    assign irq = |port_irq;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready = !w_held_ff;

    // Address hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            awaddr_ff <= 5'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[4:2], 2'h0};
        end
        else if (wr_go)
            aw_held_ff <= 1'b0;
    end

    // Data hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        else if (wr_go)
            w_held_ff <= 1'b0;
    end

    // Write decode; status words accept writes silently
    always_comb
    begin
        case (wreq.addr)
            umsi_pkg::ADDR_STATUS_P1,
            umsi_pkg::ADDR_ENABLE_P1,
            umsi_pkg::ADDR_STATUS_P2,
            umsi_pkg::ADDR_ENABLE_P2,
            umsi_pkg::ADDR_IRQ_STAT,
            umsi_pkg::ADDR_IRQ_MASK: wr_hit = (awaddr_ff == wreq.addr);
            default: wr_hit = 1'b0;
        endcase
    end

    // Response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= umsi_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? umsi_pkg::RESP_OKAY : umsi_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // Read mux
    always_comb
    begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (rd_addr)
            umsi_pkg::ADDR_STATUS_P1: rd_word[7:0] = status_word(level_ff[0], delta_ff[0]);
            umsi_pkg::ADDR_STATUS_P2: rd_word[7:0] = status_word(level_ff[1], delta_ff[1]);
            umsi_pkg::ADDR_ENABLE_P1: rd_word[IE_W-1:0] = ier_ff[0];
            umsi_pkg::ADDR_ENABLE_P2: rd_word[IE_W-1:0] = ier_ff[1];
            umsi_pkg::ADDR_IRQ_STAT: rd_word[NPORT-1:0] = ist_ff;
            umsi_pkg::ADDR_IRQ_MASK: rd_word[NPORT-1:0] = imask_ff;
            default: rd_hit = 1'b0;
        endcase
        if (s_axi_araddr[ADDR_W-1:5] != '0)
            rd_hit = 1'b0;
        if (!rd_hit)
            rd_word = 32'h0000_0000;
    end

    // Read data register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= umsi_pkg::RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? umsi_pkg::RESP_OKAY : umsi_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule : umsi_top
